// ---- logic/wiper_write_protect_and_otp_map.sv ----
`timescale 1ns/1ps
module wiper_write_protect_and_otp_map #(
	parameter logic [27:0] PROG_WAIT   = wiper_pkg::PROG_CYCLES,
	parameter logic [9:0]  TOL_HI_INIT = 10'h000,
	parameter logic [9:0]  TOL_LO_INIT = 10'h000
) (
	input  wire logic                         i_clk,
	input  wire logic                         i_rst_n,
	input  wire logic                         i_ce,
	input  wire logic                         i_reset_pin_n,
	input  wire logic                         i_cmd_valid,
	input  wire logic [wiper_pkg::WORD_W-1:0] i_cmd_word,
	output logic                              o_cmd_ready,
	output logic [wiper_pkg::WORD_W-1:0]      o_readback,
	output logic                              o_readback_valid,
	output logic [wiper_pkg::DATA_W-1:0]      o_wiper_position_register,
	output logic [wiper_pkg::DATA_W-1:0]      o_protection_control
);
	import wiper_pkg::*;

	// ==================================================
	// reset pin synchroniser
	logic [2:0] rpin_q;
	logic       rpin_lvl_q;
	logic       rpin_fall;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rpin_q     <= 3'b111;
			rpin_lvl_q <= 1'b1;
		end else if (i_ce) begin
			rpin_q <= {rpin_q[1:0], i_reset_pin_n};
			if (rpin_q[1] == rpin_q[2])
				rpin_lvl_q <= rpin_q[2];
		end
	end
	assign rpin_fall = rpin_lvl_q && (rpin_q[1] == rpin_q[2]) && !rpin_q[2];

	// ==================================================
	// command decode
	logic [3:0]        code;
	logic [DATA_W-1:0] data;
	logic              take;
	assign code = i_cmd_word[CODE_HI:CODE_LO];
	assign data = i_cmd_word[DATA_W-1:0];

	function automatic logic is_cmd(input logic [3:0] c, input logic [3:0] want);
		is_cmd = (c == want);
	endfunction : is_cmd

	// ==================================================
	// state
	prog_state_t       st_q, st_d;
	logic [27:0]       cnt_q;
	logic [DATA_W-1:0] wiper_q;
	logic              prog_en_q, unlock_q, success_q;
	logic [5:0]        last_loc_q;
	logic [2:0]        init_q;
	logic [15:0]       rb_q;
	logic              rb_valid_q;
	logic [1:0]        rd_src_q;

	localparam logic [1:0] SRC_NONE  = 2'd0;
	localparam logic [1:0] SRC_STORE = 2'd1;

	// commands wait while programming runs or while the power-up tolerance writes count down
	assign take = i_cmd_valid && (st_q == ST_IDLE) && (init_q == 3'd0);

	logic do_wr_wiper, do_store, do_refresh, do_rd_store, do_wr_ctrl;
	logic store_full;
	assign store_full  = (last_loc_q == LOC_LAST);
	assign do_wr_wiper = take && is_cmd(code, CMD_WR_WIPER) && unlock_q;
	assign do_store    = take && is_cmd(code, CMD_STORE) && prog_en_q
		&& !store_full;
	assign do_refresh  = take && is_cmd(code, CMD_REFRESH);
	assign do_rd_store = take && is_cmd(code, CMD_RD_STORE);
	assign do_wr_ctrl  = take && is_cmd(code, CMD_WR_CTRL);

	// ==================================================
	// store memory
	logic       mem_we;
	logic [5:0] mem_waddr;
	logic [9:0] mem_wdata;
	logic [5:0] mem_raddr;
	logic [9:0] mem_rdata;
	logic [5:0] next_loc;
	assign next_loc  = last_loc_q + 6'h01;
	assign mem_we    = (init_q == 3'd3) || (init_q == 3'd2) || do_store;
	assign mem_waddr = (init_q == 3'd3) ? LOC_TOL_HI : (init_q == 3'd2) ? LOC_TOL_LO : next_loc;
	assign mem_wdata = (init_q == 3'd3) ? TOL_HI_INIT : (init_q == 3'd2) ? TOL_LO_INIT : wiper_q;
	assign mem_raddr = do_rd_store ? data[LOC_W-1:0] : last_loc_q;

	store_mem u_store (
		.i_clk   (i_clk),
		.i_ce    (i_ce),
		.i_we    (mem_we),
		.i_waddr (mem_waddr),
		.i_wdata (mem_wdata),
		.i_raddr (mem_raddr),
		.o_rdata (mem_rdata)
	);

	// refresh fetches last stored value one cycle later
	logic refresh_pend_q;
	logic refresh_go;
	assign refresh_go = do_refresh || rpin_fall;

	// ==================================================
	// programming timer
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: if (do_store) st_d = ST_BUSY;
			ST_BUSY: if (cnt_q >= PROG_WAIT - 28'd1) st_d = ST_DONE;
			ST_DONE: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q  <= ST_IDLE;
			cnt_q <= 28'd0;
		end else if (i_ce) begin
			st_q  <= st_d;
			cnt_q <= (st_q == ST_BUSY) ? cnt_q + 28'd1 : 28'd0;
		end
	end

	// ==================================================
	// control register and wiper
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prog_en_q  <= 1'b0;
			unlock_q   <= 1'b0;
			success_q  <= 1'b0;
			last_loc_q <= 6'h00;
			init_q     <= 3'd3;
		end else if (i_ce) begin
			if (init_q != 3'd0)
				init_q <= init_q - 3'd1;
			if (do_wr_ctrl) begin
				prog_en_q <= data[CTRL_PROG_EN];
				unlock_q  <= data[CTRL_UNLOCK];
			end
			if (do_store) begin
				last_loc_q <= next_loc;
				success_q  <= 1'b0;
			end
			if (st_q == ST_DONE)
				success_q <= 1'b1;
		end
	end

	// wiper starts midscale; a refresh command or reset-pin fall then takes the last stored value
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wiper_q        <= MIDSCALE;
			refresh_pend_q <= 1'b0;
		end else if (i_ce) begin
			refresh_pend_q <= refresh_go;
			if (do_wr_wiper)
				wiper_q <= data;
			else if (refresh_pend_q)
				wiper_q <= (last_loc_q == 6'h00) ? MIDSCALE : mem_rdata;
		end
	end

	// ==================================================
	// readback: each taken word shifts out the prior result
	logic [15:0] rb_d;
	logic [9:0]  ctrl_word;
	assign ctrl_word = {6'h00, success_q, 1'b0, unlock_q, prog_en_q};

	always_comb begin
		rb_d = 16'h0000;
		case (code)
			CMD_RD_WIPER: rb_d = {6'h00, wiper_q};
			CMD_RD_LAST:  rb_d = {10'h000, last_loc_q};
			CMD_RD_CTRL:  rb_d = {6'h00, ctrl_word};
			default:      rb_d = i_cmd_word;
		endcase
	end

	// store read port is shared with refresh, so hold the fetched word here
	logic [15:0] prep_q;
	logic        rd_pend_q;
	logic [9:0]  store_rd_q;
	logic [9:0]  store_word;
	assign store_word = rd_pend_q ? mem_rdata : store_rd_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_pend_q  <= 1'b0;
			store_rd_q <= 10'h000;
		end else if (i_ce) begin
			rd_pend_q <= do_rd_store;
			if (rd_pend_q)
				store_rd_q <= mem_rdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prep_q     <= 16'h0000;
			rd_src_q   <= SRC_NONE;
			rb_q       <= 16'h0000;
			rb_valid_q <= 1'b0;
		end else if (i_ce) begin
			rb_valid_q <= take;
			if (take) begin
				rb_q     <= (rd_src_q == SRC_STORE) ? {6'h00, store_word} : prep_q;
				prep_q   <= rb_d;
				rd_src_q <= do_rd_store ? SRC_STORE : SRC_NONE;
			end
		end
	end

	// ==================================================
	// outputs
	logic ready_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			ready_q <= 1'b0;
		else if (i_ce)
			ready_q <= (st_d == ST_IDLE) && (init_q <= 3'd1) && !take;
	end

	assign o_cmd_ready               = ready_q;
	assign o_readback                = rb_q;
	assign o_readback_valid          = rb_valid_q;
	assign o_wiper_position_register = wiper_q;
	assign o_protection_control      = ctrl_word;
endmodule : wiper_write_protect_and_otp_map

// ---- logic/wiper_pkg.sv ----
package wiper_pkg;
	// ==================================================
	// command word layout
	localparam int        WORD_W        = 16;
	localparam int        DATA_W        = 10;
	localparam int        CODE_HI       = 13;
	localparam int        CODE_LO       = 10;
	localparam int        LOC_W         = 6;
	localparam logic [3:0] CMD_NOP      = 4'h0;
	localparam logic [3:0] CMD_WR_WIPER = 4'h1;
	localparam logic [3:0] CMD_RD_WIPER = 4'h2;
	localparam logic [3:0] CMD_STORE    = 4'h3;
	localparam logic [3:0] CMD_REFRESH  = 4'h4;
	localparam logic [3:0] CMD_RD_STORE = 4'h5;
	localparam logic [3:0] CMD_RD_LAST  = 4'h6;
	localparam logic [3:0] CMD_WR_CTRL  = 4'h7;
	localparam logic [3:0] CMD_RD_CTRL  = 4'h8;
	// ==================================================
	// control register fields
	localparam int        CTRL_PROG_EN  = 0;
	localparam int        CTRL_UNLOCK   = 1;
	localparam int        CTRL_SUCCESS  = 3;
	localparam logic [9:0] CTRL_RESET   = 10'h000;
	// ==================================================
	// store map
	localparam logic [5:0] LOC_FIRST    = 6'h01;
	localparam logic [5:0] LOC_LAST     = 6'h32;
	localparam logic [5:0] LOC_TOL_HI   = 6'h39;
	localparam logic [5:0] LOC_TOL_LO   = 6'h3a;
	localparam logic [9:0] MIDSCALE     = 10'h200;
	// ==================================================
	// timing
	localparam int        CLK_MHZ       = 100;
	localparam int        PROG_TIME_MS  = 350;
	localparam longint    PROG_CYCLES_L = longint'(PROG_TIME_MS) * 1000 * CLK_MHZ;
	localparam logic [27:0] PROG_CYCLES = PROG_CYCLES_L[27:0];
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_DONE = 3'b100
	} prog_state_t;
endpackage : wiper_pkg

// ---- logic/store_mem.sv ----
`timescale 1ns/1ps
module store_mem (
	input  wire logic       i_clk,
	input  wire logic       i_ce,
	input  wire logic       i_we,
	input  wire logic [5:0] i_waddr,
	input  wire logic [9:0] i_wdata,
	input  wire logic [5:0] i_raddr,
	output logic      [9:0] o_rdata
);
	logic [9:0] mem [0:63];
	// no reset: contents model nonvolatile cells, loaded by the parent
	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			if (i_we)
				mem[i_waddr] <= i_wdata;
			o_rdata <= mem[i_raddr];
		end
	end
endmodule : store_mem

// ---- test/wiper_monitor.sv ----
`timescale 1ns/1ps
module wiper_monitor (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_ce,
	input wire logic        i_reset_pin_n,
	input wire logic        i_cmd_valid,
	input wire logic [15:0] i_cmd_word,
	input wire logic        o_cmd_ready,
	input wire logic [15:0] o_readback,
	input wire logic        o_readback_valid,
	input wire logic [9:0]  o_wiper_position_register,
	input wire logic [9:0]  o_protection_control
);
	import wiper_pkg::*;
	wire       take = i_ce & i_cmd_valid & o_cmd_ready;
	wire [3:0] code = i_cmd_word[13:10];
	wire [9:0] dat  = i_cmd_word[9:0];
	wire [9:0] ctl  = o_protection_control;
	wire [9:0] wip  = o_wiper_position_register;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ==================================================
	// checks
	property p_ctrl_map; ctl[9:4] == 6'h00 && !ctl[2]; endproperty
	a_ctrl_map: assert property (p_ctrl_map) else $error("spare control bit set");
	property p_locked; take && code == CMD_WR_WIPER && !ctl[1] && i_reset_pin_n |=> $stable(wip);
	endproperty
	a_locked: assert property (p_locked) else $error("locked wiper moved");
	property p_unlocked; take && code == CMD_WR_WIPER && ctl[1] |=> wip == $past(dat); endproperty
	a_unlocked: assert property (p_unlocked) else $error("wiper write lost");
	property p_ctrl_load; take && code == CMD_WR_CTRL |=> ctl[1:0] == $past(dat[1:0]); endproperty
	a_ctrl_load: assert property (p_ctrl_load) else $error("control load wrong");
	property p_answer; take |=> o_readback_valid; endproperty
	a_answer: assert property (p_answer) else $error("no readback pulse");
	property p_quiet; !take |=> !o_readback_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("stray readback pulse");
	property p_busy; take && code == CMD_STORE && ctl[0] |=> !o_cmd_ready [*8]; endproperty
	a_busy: assert property (p_busy) else $error("input open while programming");
	property p_success; $rose(ctl[3]) |-> ctl[0]; endproperty
	a_success: assert property (p_success) else $error("success without enable");
endmodule : wiper_monitor
bind wiper_write_protect_and_otp_map wiper_monitor u_mon (.i_clk, .i_rst_n, .i_ce, .i_reset_pin_n,
	.i_cmd_valid, .i_cmd_word, .o_cmd_ready, .o_readback, .o_readback_valid,
	.o_wiper_position_register, .o_protection_control);

// ---- test/cmd_host.sv ----
`timescale 1ns/1ps
module cmd_host (
	input  wire logic        i_clk,
	input  wire logic        i_cmd_ready,
	input  wire logic [15:0] i_readback,
	output logic             o_cmd_valid,
	output logic      [15:0] o_cmd_word
);
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_word  = 16'h0000;
	end
	// ==================================================
	// one word per call; readback is the previous result
	task send(input logic [15:0] c, output logic [15:0] r);
		int n;
		n = 0;
		@(posedge i_clk);
		o_cmd_valid <= 1'b1;
		o_cmd_word  <= {2'b00, c[13:0]};
		do @(posedge i_clk); while (i_cmd_ready !== 1'b1 && ++n < 300);
		o_cmd_valid <= 1'b0;
		@(posedge i_clk);
		#1 r = i_readback;
	endtask : send
endmodule : cmd_host

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
	import wiper_pkg::*;
	localparam logic [9:0] TOL_HI = 10'h0ab;
	localparam logic [9:0] TOL_LO = 10'h135;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        ce = 1'b1;
	logic        pin_n = 1'b1;
	logic        valid, ready, rb_valid;
	logic [15:0] word, rb, r;
	logic [9:0]  wiper, ctrl;
	int          n_fail = 0, compares = 0, cyc = 0;
	always #5 i_clk = ~i_clk;
	wiper_write_protect_and_otp_map #(.PROG_WAIT(28'd20), .TOL_HI_INIT(TOL_HI),
		.TOL_LO_INIT(TOL_LO)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
		.i_reset_pin_n(pin_n), .i_cmd_valid(valid), .i_cmd_word(word), .o_cmd_ready(ready),
		.o_readback(rb), .o_readback_valid(rb_valid), .o_wiper_position_register(wiper),
		.o_protection_control(ctrl));
	cmd_host host (.i_clk(i_clk), .i_cmd_ready(ready), .i_readback(rb), .o_cmd_valid(valid),
		.o_cmd_word(word));
	task end_of_test;
		if (n_fail == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// masked compare of what the word before this one prepared
	task cmd(input logic [15:0] c, input logic [15:0] e, input logic [15:0] m);
		host.send(c, r);
		chk("readback", e, r & m);
	endtask : cmd
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		chk("ctrl", 16'h0000, {6'h00, ctrl});
		chk("wiper", 16'h0200, {6'h00, wiper});
		cmd(16'h0500, 16'h0000, 16'h0000);
		chk("wiper", 16'h0200, {6'h00, wiper});
		cmd(16'h0c00, 16'h0500, 16'hffff);
		cmd(16'h1800, 16'h0c00, 16'hffff);
		cmd(16'h0000, 16'h0000, 16'h003f);
		chk("ctrl", 16'h0000, {6'h00, ctrl});
		cmd(16'h1c03, 16'h0000, 16'hffff);
		chk("ctrl", 16'h0003, {6'h00, ctrl});
		cmd(16'h0500, 16'h1c03, 16'hffff);
		chk("wiper", 16'h0100, {6'h00, wiper});
		cmd(16'h0800, 16'h0500, 16'hffff);
		cmd(16'h0c00, 16'h0100, 16'h03ff);
		cmd(16'h1800, 16'h0c00, 16'hffff);
		chk("ctrl", 16'h000b, {6'h00, ctrl});
		cmd(16'h0000, 16'h0001, 16'h003f);
		cmd(16'h06aa, 16'h0000, 16'hffff);
		cmd(16'h0c00, 16'h06aa, 16'hffff);
		cmd(16'h1402, 16'h0c00, 16'hffff);
		cmd(16'h1401, 16'h02aa, 16'h03ff);
		cmd(16'h1439, 16'h0100, 16'h03ff);
		cmd(16'h143a, {6'h00, TOL_HI}, 16'h03ff);
		cmd(16'h2000, {6'h00, TOL_LO}, 16'h03ff);
		cmd(16'h1800, 16'h000b, 16'h000f);
		cmd(16'h0000, 16'h0002, 16'h003f);
		cmd(16'h07ff, 16'h0000, 16'hffff);
		cmd(16'h1c00, 16'h07ff, 16'hffff);
		chk("ctrl", 16'h0008, {6'h00, ctrl});
		cmd(16'h0400, 16'h1c00, 16'hffff);
		chk("wiper", 16'h03ff, {6'h00, wiper});
		cmd(16'h1000, 16'h0400, 16'hffff);
		repeat (3) @(posedge i_clk);
		chk("wiper", 16'h02aa, {6'h00, wiper});
		cmd(16'h1c03, 16'h1000, 16'hffff);
		cmd(16'h0455, 16'h1c03, 16'hffff);
		chk("wiper", 16'h0055, {6'h00, wiper});
		// pin pulse while frozen must wait for the enable
		@(posedge i_clk);
		ce    <= 1'b0;
		pin_n <= 1'b0;
		repeat (6) @(posedge i_clk);
		chk("frozen wiper", 16'h0055, {6'h00, wiper});
		ce <= 1'b1;
		repeat (6) @(posedge i_clk);
		pin_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk("pin refresh", 16'h02aa, {6'h00, wiper});
		end_of_test();
	end
endmodule : tb
